// ==== fcs_params.svh ====
/*
  Constants for the flash command sequencer: command codes, offsets,
  status bit positions and timing counts.
  Assumes inclusion by bare name from each end's module file.
*/
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
`define FCS_OFS_AAA 12'haaa
`define FCS_OFS_554 12'h554
`define FCS_CMD_AA 8'haa
`define FCS_CMD_55 8'h55
`define FCS_CMD_F0 8'hf0
`define FCS_CMD_A0 8'ha0
`define FCS_CMD_80 8'h80
`define FCS_CMD_10 8'h10
`define FCS_CMD_30 8'h30
`define FCS_CMD_B0 8'hb0
`define FCS_RST_HI_A 8'hff
`define FCS_RST_HI_B 8'hfe
`define FCS_BIT_POLL 7
`define FCS_BIT_TOGGLE 6
`define FCS_BIT_TMO 5
`define FCS_BIT_ETMR 3
`define FCS_NSECT 3
`define FCS_SECT_EN_RST 3'h0
`define FCS_PROG_CYC 16'h0028
`define FCS_ERASE_CYC 16'h0400
`define FCS_EWAIT_CYC 16'h0020
`define FCS_LIMIT_CYC 16'h0800
`endif

// ==== fcs_pkg.sv ====
/*
  Types shared by both ends of the flash command sequencer.
  Assumes no surroundings beyond a SystemVerilog compiler.
*/
package fcs_pkg;
  // Sequencer states of the device end
  typedef enum logic [3:0] {
    FCS_IDLE, FCS_C1, FCS_C2, FCS_PGM_DATA, FCS_E3, FCS_E4, FCS_E5,
    FCS_RST3, FCS_PROG, FCS_EWAIT, FCS_ERASE, FCS_SUSP
  } fcs_state_t;
  // Commands the host end can issue
  typedef enum logic [2:0] {
    FCS_OP_RESET, FCS_OP_PROG, FCS_OP_CHIP, FCS_OP_SECT,
    FCS_OP_SUSP, FCS_OP_RESUME
  } fcs_op_t;
endpackage

// ==== fcs_bus_if.sv ====
/*
  CPU-side flash bus between host and sequencer.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface fcs_bus_if;
  logic wr;
  logic rd;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport dev (input wr, input rd, input addr, input wdata, output rdata);
  modport host (output wr, output rd, output addr, output wdata, input rdata);
endinterface

// ==== fcs_device.sv ====
/*
  Device end: command decoder, algorithm timers, status flag read path
  and a small array model. Assumes writes and reads are one-cycle strobes
  synchronous to clk_i; read data appears the cycle after a read strobe.
*/
`timescale 1ns/10ps
`include "fcs_params.svh"
module fcs_device (
  input wire logic clk_i,
  input wire logic rst_n_i,
  fcs_bus_if.dev bus,
  input wire logic [`FCS_NSECT-1:0] sector_write_enable_i,
  output logic busy_o,
  output logic [3:0] state_o
);
  // ==========================================================
  // Decode
  logic [7:0] mem_reg [0:4095];
  fcs_pkg::fcs_state_t state_reg, state_next;
  logic [3:0] nib_reg, nib_next;
  logic [11:0] tgt_reg;
  logic [7:0] last_reg;
  logic [15:0] cnt_reg, tot_reg;
  logic tog_reg, tmo_reg, chip_reg;
  logic [7:0] rdata_reg;
  wire [11:0] low = bus.addr[11:0];
  wire [3:0] nib = bus.addr[15:12];
  wire [7:0] d = bus.wdata;
  wire at_aaa = (low == `FCS_OFS_AAA);
  wire at_554 = (low == `FCS_OFS_554);
  wire nib_ok = (nib == nib_reg);
  wire all_en = &sector_write_enable_i;
  wire quick_rst = bus.wr && (d == `FCS_CMD_F0) &&
    (bus.addr[15:8] == `FCS_RST_HI_A || bus.addr[15:8] == `FCS_RST_HI_B);
  wire cnt_done = (cnt_reg == 16'h0000);
  wire tmo_hit = (tot_reg >= `FCS_LIMIT_CYC);
  // Sector of an address: 1 KiB slices of the 4 KiB model array
  function automatic logic [1:0] sect_of(input logic [11:0] a);
    sect_of = a[11:10];
  endfunction
  function automatic logic sect_en(input logic [11:0] a);
    sect_en = (sect_of(a) < 2'd3) ? sector_write_enable_i[sect_of(a)] : 1'b1;
  endfunction
  wire in_tgt = chip_reg || (sect_of(low) == sect_of(tgt_reg) && nib_ok);

  // Next state; a mismatch in an unlock or command cycle drops back to idle unrecognised, while suspend ignores other writes except a short reset
  always_comb begin
    state_next = state_reg;
    nib_next = nib_reg;
    case (state_reg)
      fcs_pkg::FCS_IDLE: if (bus.wr && d == `FCS_CMD_AA && at_aaa) begin
        state_next = fcs_pkg::FCS_C1;
        nib_next = nib;
      end
      fcs_pkg::FCS_C1: if (bus.wr) begin
        state_next = (d == `FCS_CMD_55 && at_554) ? fcs_pkg::FCS_C2 : fcs_pkg::FCS_IDLE;
      end
      fcs_pkg::FCS_C2: if (bus.wr) begin
        state_next = fcs_pkg::FCS_IDLE;
        if (at_aaa && nib_ok && d == `FCS_CMD_A0)
          state_next = fcs_pkg::FCS_PGM_DATA;
        else if (at_aaa && d == `FCS_CMD_80)
          state_next = fcs_pkg::FCS_E3;
        else if (at_aaa && nib_ok && d == `FCS_CMD_F0)
          state_next = fcs_pkg::FCS_RST3;
      end
      fcs_pkg::FCS_RST3: if (bus.wr || bus.rd) state_next = fcs_pkg::FCS_IDLE;
      fcs_pkg::FCS_PGM_DATA: if (bus.wr) begin
        state_next = (nib_ok && sect_en(low)) ? fcs_pkg::FCS_PROG : fcs_pkg::FCS_IDLE;
      end
      fcs_pkg::FCS_E3: if (bus.wr) begin
        state_next = (d == `FCS_CMD_AA && at_aaa) ? fcs_pkg::FCS_E4 : fcs_pkg::FCS_IDLE;
      end
      fcs_pkg::FCS_E4: if (bus.wr) begin
        state_next = (d == `FCS_CMD_55 && at_554) ? fcs_pkg::FCS_E5 : fcs_pkg::FCS_IDLE;
      end
      fcs_pkg::FCS_E5: if (bus.wr) begin
        state_next = fcs_pkg::FCS_IDLE;
        if (d == `FCS_CMD_10 && at_aaa && all_en)
          state_next = fcs_pkg::FCS_ERASE;
        else if (d == `FCS_CMD_30 && nib_ok && sect_en(low))
          state_next = fcs_pkg::FCS_EWAIT;
      end
      // Busy programming: only finish or fail, commands ignored
      fcs_pkg::FCS_PROG: if (cnt_done) state_next = fcs_pkg::FCS_IDLE;
      fcs_pkg::FCS_EWAIT: if (cnt_done) state_next = fcs_pkg::FCS_ERASE;
      fcs_pkg::FCS_ERASE: begin
        if (cnt_done) state_next = fcs_pkg::FCS_IDLE;
        else if (bus.wr && !chip_reg && d == `FCS_CMD_B0 && nib_ok)
          state_next = fcs_pkg::FCS_SUSP;
      end
      fcs_pkg::FCS_SUSP: if (bus.wr && d == `FCS_CMD_30 && nib_ok)
        state_next = fcs_pkg::FCS_ERASE;
      default: state_next = fcs_pkg::FCS_IDLE;
    endcase
    // Short reset wins except while a healthy algorithm owns the array;
    // a timed-out one can only be left this way
    if (quick_rst && (tmo_reg || (state_reg != fcs_pkg::FCS_PROG &&
        state_reg != fcs_pkg::FCS_ERASE && state_reg != fcs_pkg::FCS_EWAIT)))
      state_next = fcs_pkg::FCS_IDLE;
  end

  // ==========================================================
  // Sequencer registers; a timed-out algorithm stays until reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= fcs_pkg::FCS_IDLE;
      nib_reg <= 4'h0;
    end else begin
      state_reg <= (tmo_reg && !quick_rst) ? state_reg : state_next;
      nib_reg <= nib_next;
    end
  end

  // Capture target, last data and load algorithm timers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgt_reg <= 12'h000;
      last_reg <= 8'h00;
      chip_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      tot_reg <= 16'h0000;
      tmo_reg <= 1'b0;
    end else begin
      if (quick_rst) tmo_reg <= 1'b0;
      else if (tmo_hit) tmo_reg <= 1'b1;
      // Reset of a timed-out run restarts the limit count, else it re-arms at once
      if (quick_rst && tmo_reg) begin
        tot_reg <= 16'h0000;
      end else if (state_next == fcs_pkg::FCS_PROG && state_reg != fcs_pkg::FCS_PROG) begin
        tgt_reg <= low;
        last_reg <= d;
        chip_reg <= 1'b0;
        cnt_reg <= `FCS_PROG_CYC;
        tot_reg <= 16'h0000;
      end else if (state_next == fcs_pkg::FCS_EWAIT && state_reg == fcs_pkg::FCS_E5) begin
        tgt_reg <= low;
        chip_reg <= 1'b0;
        cnt_reg <= `FCS_EWAIT_CYC;
        tot_reg <= 16'h0000;
      end else if (state_next == fcs_pkg::FCS_ERASE && state_reg == fcs_pkg::FCS_E5) begin
        chip_reg <= 1'b1;
        cnt_reg <= `FCS_ERASE_CYC;
        tot_reg <= 16'h0000;
      end else if (state_reg == fcs_pkg::FCS_EWAIT && cnt_done) begin
        cnt_reg <= `FCS_ERASE_CYC;
      end else if (state_reg == fcs_pkg::FCS_PROG || state_reg == fcs_pkg::FCS_ERASE ||
                   state_reg == fcs_pkg::FCS_EWAIT) begin
        // A 0-to-1 program never finishes: the array cannot set bits
        if (!(state_reg == fcs_pkg::FCS_PROG && |(last_reg & ~mem_reg[tgt_reg])))
          cnt_reg <= cnt_done ? cnt_reg : cnt_reg - 16'h0001;
        tot_reg <= tmo_hit ? tot_reg : tot_reg + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Array model: program ANDs in data, erase sets bytes to ff
  always_ff @(posedge clk_i) begin
    if (state_reg == fcs_pkg::FCS_PROG && cnt_done)
      mem_reg[tgt_reg] <= mem_reg[tgt_reg] & last_reg;
    else if (state_reg == fcs_pkg::FCS_ERASE && cnt_done) begin
      for (int i = 0; i < 4096; i++) begin
        if (chip_reg || sect_of(12'(i)) == sect_of(tgt_reg)) mem_reg[i] <= 8'hff;
      end
    end
  end

  // ==========================================================
  // Read path: status flags in place of data on target reads
  wire busy = (state_reg == fcs_pkg::FCS_PROG) || (state_reg == fcs_pkg::FCS_EWAIT) ||
    (state_reg == fcs_pkg::FCS_ERASE);
  wire prog_hit = (state_reg == fcs_pkg::FCS_PROG) && nib_ok &&
    (sect_of(low) == sect_of(tgt_reg));
  wire erase_hit = busy && !prog_hit && in_tgt;
  wire susp_hit = (state_reg == fcs_pkg::FCS_SUSP) && in_tgt;
  wire [7:0] arr = mem_reg[low];
  wire [7:0] flags = {
    prog_hit ? ~last_reg[7] : 1'b0,
    tog_reg, tmo_reg, 1'b0,
    state_reg != fcs_pkg::FCS_EWAIT && !prog_hit, 3'b000
  };
  wire [7:0] susp_val = {1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'b000};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 8'h00;
      tog_reg <= 1'b0;
    end else if (bus.rd) begin
      if (prog_hit || erase_hit) begin
        rdata_reg <= flags;
        tog_reg <= ~tog_reg;
      end else if (susp_hit) rdata_reg <= susp_val;
      else rdata_reg <= arr;
    end
  end

  assign bus.rdata = rdata_reg;
  assign busy_o = busy;
  assign state_o = state_reg;
endmodule

// ==== fcs_host.sv ====
/*
  Host end: plays a command as a burst of bus writes, then reads status when rd_i asks.
  Assumes the device answers a read strobe with data one cycle later.
*/
`timescale 1ns/10ps
`include "fcs_params.svh"
module fcs_host (
  input wire logic clk_i,
  input wire logic rst_n_i,
  fcs_bus_if.host bus,
  input wire logic start_i,
  input wire fcs_pkg::fcs_op_t op_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic rd_i,
  output logic ready_o,
  output logic [7:0] rdata_o
);
  // ==========================================================
  // Cycle table; the upper nibble of addr_i rides every cycle except the reset write, which goes to ff00
  logic [2:0] step_reg, len_reg;
  fcs_pkg::fcs_op_t op_reg;
  logic [15:0] a_reg;
  logic [7:0] d_reg;
  logic act_reg, wr_reg, rd_reg, rdv_reg;
  logic [15:0] cyc_a;
  logic [7:0] cyc_d;
  logic [7:0] rdata_reg;
  wire [3:0] u = a_reg[15:12];

  function automatic logic [2:0] op_len(input fcs_pkg::fcs_op_t o);
    case (o)
      fcs_pkg::FCS_OP_RESET: op_len = 3'd1;
      fcs_pkg::FCS_OP_PROG: op_len = 3'd4;
      fcs_pkg::FCS_OP_CHIP: op_len = 3'd6;
      fcs_pkg::FCS_OP_SECT: op_len = 3'd6;
      default: op_len = 3'd1;
    endcase
  endfunction

  // Address and data of the current cycle
  always_comb begin
    cyc_a = {u, `FCS_OFS_AAA};
    cyc_d = `FCS_CMD_AA;
    if (op_reg == fcs_pkg::FCS_OP_RESET) begin
      cyc_a = {`FCS_RST_HI_A, 8'h00};
      cyc_d = `FCS_CMD_F0;
    end else if (op_reg == fcs_pkg::FCS_OP_SUSP || op_reg == fcs_pkg::FCS_OP_RESUME) begin
      cyc_a = a_reg;
      cyc_d = (op_reg == fcs_pkg::FCS_OP_SUSP) ? `FCS_CMD_B0 : `FCS_CMD_30;
    end else begin
      case (step_reg)
        3'd1, 3'd4: begin
          cyc_a = {u, `FCS_OFS_554};
          cyc_d = `FCS_CMD_55;
        end
        3'd2: cyc_d = (op_reg == fcs_pkg::FCS_OP_PROG) ? `FCS_CMD_A0 : `FCS_CMD_80;
        3'd3: begin
          cyc_a = (op_reg == fcs_pkg::FCS_OP_PROG) ? a_reg : {u, `FCS_OFS_AAA};
          cyc_d = (op_reg == fcs_pkg::FCS_OP_PROG) ? d_reg : `FCS_CMD_AA;
        end
        3'd5: begin
          cyc_a = (op_reg == fcs_pkg::FCS_OP_SECT) ? a_reg : {u, `FCS_OFS_AAA};
          cyc_d = (op_reg == fcs_pkg::FCS_OP_SECT) ? `FCS_CMD_30 : `FCS_CMD_10;
        end
        default: cyc_d = `FCS_CMD_AA;
      endcase
    end
  end

  // ==========================================================
  // Burst sequencer: cycles go back to back, none interleaved
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_reg <= 1'b0;
      step_reg <= 3'd0;
      len_reg <= 3'd1;
      op_reg <= fcs_pkg::FCS_OP_RESET;
      a_reg <= 16'h0000;
      d_reg <= 8'h00;
    end else if (!act_reg && start_i) begin
      act_reg <= 1'b1;
      step_reg <= 3'd0;
      len_reg <= op_len(op_i);
      op_reg <= op_i;
      a_reg <= addr_i;
      d_reg <= data_i;
    end else if (act_reg) begin
      step_reg <= step_reg + 3'd1;
      if (step_reg + 3'd1 == len_reg) act_reg <= 1'b0;
    end
  end

  // Read strobe and returned data
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_reg <= 1'b0;
      rdv_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      rd_reg <= !act_reg && !start_i && rd_i && !rd_reg;
      rdv_reg <= rd_reg;
      if (rdv_reg) rdata_reg <= bus.rdata;
    end
  end

  assign wr_reg = act_reg;
  assign bus.wr = wr_reg;
  assign bus.rd = rd_reg;
  assign bus.addr = act_reg ? cyc_a : a_reg;
  assign bus.wdata = cyc_d;
  assign ready_o = !act_reg && !rd_reg && !rdv_reg;
  assign rdata_o = rdata_reg;
endmodule

// ==== fcs_chk_sva.sv ====
/*
  Checker for the flash command sequencer: watches the shared bus and the
  device status ports. Assumes the testbench instantiates it beside the bus.
*/
`timescale 1ns/10ps
`include "fcs_params.svh"
module fcs_chk (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic [`FCS_NSECT-1:0] sector_write_enable_i,
  input wire logic busy_o,
  input wire logic [3:0] state_o
);
  // ==========================================
  // Helper state
  logic [15:0] pa_reg;
  logic [5:0] es_reg;
  logic pbit_reg, frd_reg, have_reg, tog_reg;
  wire frd = rd && state_o == fcs_pkg::FCS_PROG && addr == pa_reg;
  // Targets of the last program and sector erase, last toggle seen
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pa_reg <= 16'h0000;
      es_reg <= 6'h00;
      pbit_reg <= 1'b0;
      frd_reg <= 1'b0;
      have_reg <= 1'b0;
      tog_reg <= 1'b0;
    end else begin
      if (state_o == fcs_pkg::FCS_PGM_DATA && wr) pa_reg <= addr;
      if (state_o == fcs_pkg::FCS_PGM_DATA && wr) pbit_reg <= wdata[7];
      if (state_o == fcs_pkg::FCS_E5 && wr) es_reg <= addr[15:10];
      frd_reg <= frd;
      if (frd_reg) tog_reg <= rdata[6];
      // Forget the toggle once idle so a new run starts afresh
      have_reg <= busy_o && (have_reg || frd_reg);
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_prog_start: assert property (state_o == fcs_pkg::FCS_PGM_DATA && wr
    |=> state_o == fcs_pkg::FCS_PROG) else $error("program did not start");
  chk_quick_reset: assert property (wr && wdata == 8'hf0 && addr[15:9] == 7'h7f &&
    !busy_o && !(state_o inside {fcs_pkg::FCS_PGM_DATA, fcs_pkg::FCS_SUSP})
    |=> state_o == fcs_pkg::FCS_IDLE) else $error("quick reset ignored");
  chk_prog_ignore: assert property (state_o == fcs_pkg::FCS_PROG
    |=> state_o inside {fcs_pkg::FCS_PROG, fcs_pkg::FCS_IDLE}) else $error("command taken");
  chk_poll_prog: assert property (frd |=> rdata[7] == !pbit_reg)
    else $error("polling bit not inverted");
  chk_toggle_flip: assert property (frd_reg && have_reg |-> rdata[6] != tog_reg)
    else $error("toggle bit did not flip");
  chk_chip_gate: assert property (state_o == fcs_pkg::FCS_E5 && wr && wdata == 8'h10 &&
    !(&sector_write_enable_i) |=> !busy_o) else $error("locked chip erase ran");
  chk_erase_flags: assert property (rd && addr[15:10] == es_reg &&
    state_o inside {fcs_pkg::FCS_EWAIT, fcs_pkg::FCS_ERASE} |=> !rdata[7] &&
    rdata[3] == ($past(state_o) == fcs_pkg::FCS_ERASE)) else $error("erase flags wrong");
  chk_susp_read: assert property (rd && state_o == fcs_pkg::FCS_SUSP &&
    addr[15:10] == es_reg |=> rdata[7:6] == 2'b11) else $error("suspended read wrong");
  chk_susp_cmd: assert property (state_o == fcs_pkg::FCS_ERASE && wr && wdata == 8'hb0 &&
    addr[15:12] == es_reg[5:2] |-> ##[1:2] state_o == fcs_pkg::FCS_SUSP)
    else $error("suspend not taken");
  chk_resume_cmd: assert property (state_o == fcs_pkg::FCS_SUSP && wr && wdata == 8'h30 &&
    addr[15:12] == es_reg[5:2] |-> ##[1:2] state_o == fcs_pkg::FCS_ERASE)
    else $error("resume not taken");
  chk_done_idle: assert property ($fell(busy_o)
    |-> state_o inside {fcs_pkg::FCS_IDLE, fcs_pkg::FCS_SUSP}) else $error("not idle at end");
endmodule

// ==== tb_flash_command_sequencer_status_flags.sv ====
/*
  Testbench: host and device ends joined by the bus, checked against a
  behavioural array model. Assumes both ends and the checker are compiled.
*/
`timescale 1ns/10ps
module tb_flash_command_sequencer_status_flags;
  logic clk_i = 1'b0, rst_n_i = 1'b0, start_i = 1'b0, rd_i = 1'b0, ready_o, busy_o;
  fcs_pkg::fcs_op_t op_i = fcs_pkg::FCS_OP_RESET;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] data_i = 8'h00, rdata_o;
  logic [2:0] sector_we = 3'h7;
  logic [3:0] state_o;
  int num_errors = 0, total_checks = 0;
  logic [7:0] mem[int];
  int q[$];
  fcs_bus_if bus ();
  fcs_device u_fcs_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus),
    .sector_write_enable_i(sector_we), .busy_o(busy_o), .state_o(state_o));
  fcs_host u_fcs_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus), .start_i(start_i),
    .op_i(op_i), .addr_i(addr_i), .data_i(data_i), .rd_i(rd_i), .ready_o(ready_o),
    .rdata_o(rdata_o));
  fcs_chk u_fcs_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr(bus.wr), .rd(bus.rd),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
    .sector_write_enable_i(sector_we), .busy_o(busy_o), .state_o(state_o));
  // ==========================================
  // Clock and hang guard
  initial forever #25 clk_i = ~clk_i;
  initial begin
    repeat (100000) @(posedge clk_i);
    hang();
  end
  // ==========================================
  // Shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang();
    num_errors++;
    tally_and_finish();
  endtask
  // Model read: erased bytes read all ones
  function automatic logic [7:0] ex(input int a);
    return mem.exists(a & 'hfff) ? mem[a & 'hfff] : 8'hff;
  endfunction
  // One command; returns once the host end is idle again
  task automatic go(input fcs_pkg::fcs_op_t op, input int a, input int d);
    int n;
    @(posedge clk_i);
    start_i <= 1'b1;
    op_i <= op;
    addr_i <= a[15:0];
    data_i <= d[7:0];
    @(posedge clk_i);
    start_i <= 1'b0;
    for (n = 0; n < 30; n++) begin
      @(negedge clk_i);
      if (ready_o === 1'b1) break;
    end
    if (n >= 30) hang();
  endtask
  // Read at the last command address; compares masked bits
  task automatic rd(input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 check(rdata_o & m, e & m);
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; busy_o !== 1'b0; n++) begin
      if (n > 3000) hang();
      @(negedge clk_i);
    end
  endtask
  // ==========================================
  // Main sequence
  initial begin
    int a, b, d;
    void'($urandom(51));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    sector_we <= 3'h6;
    go(fcs_pkg::FCS_OP_CHIP, 'h0aaa, 0);
    repeat (4) @(posedge clk_i);
    #1 check({7'h00, busy_o}, 8'h00);
    sector_we <= 3'h7;
    go(fcs_pkg::FCS_OP_CHIP, 'h0aaa, 0);
    rd(8'ha8, 8'h08);
    wait_idle();
    rd(8'hff, 8'hff);
    $display("chip erase test done");
    for (int i = 0; i < 3; i++) begin
      a = $urandom;
      a = {a[15:12], 2'b01, i[1:0], a[7:0]};
      d = $urandom_range(255);
      q.push_back(a);
      go(fcs_pkg::FCS_OP_PROG, a, d);
      rd(8'ha8, {~d[7], 7'h00});
      rd(8'h80, {~d[7], 7'h00});
      b = a ^ 'h0800;
      // A second program while busy must leave its byte erased
      go(fcs_pkg::FCS_OP_PROG, b, 0);
      wait_idle();
      mem[a & 'hfff] = d[7:0] & ex(a);
      go(fcs_pkg::FCS_OP_RESET, a, 0);
      rd(8'hff, ex(a));
      go(fcs_pkg::FCS_OP_RESET, b, 0);
      rd(8'hff, ex(b));
    end
    $display("program test done");
    a = q[0];
    b = {a[15:12], 2'b10, a[9:0]};
    go(fcs_pkg::FCS_OP_PROG, b, 'h5a);
    wait_idle();
    mem[b & 'hfff] = 8'h5a;
    go(fcs_pkg::FCS_OP_SECT, a, 0);
    rd(8'ha8, 8'h00);
    // Erase wait period is a fixed count, so a fixed pause passes it
    repeat (40) @(posedge clk_i);
    rd(8'ha8, 8'h08);
    go(fcs_pkg::FCS_OP_SUSP, a, 0);
    rd(8'hc0, 8'hc0);
    go(fcs_pkg::FCS_OP_SUSP, b, 0);
    rd(8'hff, ex(b));
    go(fcs_pkg::FCS_OP_RESUME, a, 0);
    wait_idle();
    foreach (q[k]) mem.delete(q[k] & 'hfff);
    go(fcs_pkg::FCS_OP_RESET, a, 0);
    rd(8'hff, ex(a));
    go(fcs_pkg::FCS_OP_RESET, b, 0);
    rd(8'hff, ex(b));
    $display("sector erase test done");
    // Setting a cleared bit can never finish, so the limit must trip
    go(fcs_pkg::FCS_OP_PROG, b, 'hff);
    repeat (2100) @(posedge clk_i);
    rd(8'ha0, 8'h20);
    go(fcs_pkg::FCS_OP_RESET, b, 0);
    rd(8'hff, ex(b));
    $display("timeout test done");
    tally_and_finish();
  end
endmodule
